// ===== src/adc_custom_sequence_config.sv
`timescale 1ns/1ps
module adc_custom_sequence_config #(
    parameter int AW = 12 // AXI address width
) (
    input wire logic ref_clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic [AW-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [AW-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic seqStart, // pulse: start a sequencer pass
    input wire logic convAck, // engine accepted presented slot
    output seq_cfg_pkg::slot_t slot, // slot for the conversion engine
    output logic seqBusy // sequencer pass running
);
    import seq_cfg_pkg::*;

    if (AW < MIN_ADDR_W || AW > 32) begin : g_aw_check
        $error("AW must be between 9 and 32");
    end

    typedef struct packed {
        logic awReady;
        logic wReady;
        logic awHeld;
        logic wHeld;
        logic [AW-1:0] wAddr;
        logic [REG_W-1:0] wData;
        logic [1:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic arReady;
        logic rValid;
        logic [REG_W-1:0] rData;
        logic [1:0] rResp;
        logic [PTR_W-1:0] startPtr;
        logic [PTR_W-1:0] stopPtr;
    } bus_t;

    bus_t s_reg;
    bus_t s_next;

    // slot codes; pair register p holds slots 2p and 2p+1
    logic [CODE_W-1:0] slotTable [SLOT_COUNT];
    logic tblWe;
    logic [PTR_W-1:0] tblEvenSlot;
    logic [PTR_W-1:0] lookIdx;
    logic [CODE_W-1:0] codeAtPtr;

    // mapped: word aligned and inside the sixty-four register window
    function automatic logic addrOk(input logic [AW-1:0] a);
        addrOk = (a[1:0] == 2'h0) && ((a >> IDX_LSB) >= AW'(PAIR_FIRST_IDX))
            && ((a >> IDX_LSB) <= AW'(BOUNDS_IDX));
    endfunction : addrOk

    function automatic logic [PTR_W-1:0] evenSlotOf(input logic [6:0] idx);
        logic [6:0] pairNo;
        pairNo = idx - PAIR_FIRST_IDX;
        // pair number stays below 64, so dropping its top bit loses nothing
        evenSlotOf = {pairNo[PTR_W-2:0], 1'b0};
    endfunction : evenSlotOf

    // bus handshakes, register writes and read mux
    always_comb begin
        logic [6:0] idx;
        logic [PTR_W-1:0] es;
        idx = '0;
        es = '0;
        s_next = s_reg;
        tblWe = 1'b0;
        tblEvenSlot = '0;
        if (s_reg.awReady && s_axi_awvalid) begin
            s_next.awReady = 1'b0;
            s_next.awHeld = 1'b1;
            s_next.wAddr = s_axi_awaddr;
        end
        if (s_reg.wReady && s_axi_wvalid) begin
            s_next.wReady = 1'b0;
            s_next.wHeld = 1'b1;
            s_next.wData = s_axi_wdata[REG_W-1:0]; // upper lanes unused
            s_next.wStrb = s_axi_wstrb[1:0];
        end
        // both halves present: commit and answer
        if (s_reg.awHeld && s_reg.wHeld) begin
            idx = s_reg.wAddr[IDX_MSB:IDX_LSB];
            s_next.awHeld = 1'b0;
            s_next.wHeld = 1'b0;
            s_next.bValid = 1'b1;
            s_next.bResp = addrOk(s_reg.wAddr) ? RESP_OKAY : RESP_SLVERR;
            if (addrOk(s_reg.wAddr) && idx == BOUNDS_IDX) begin
                if (s_reg.wStrb[0]) begin
                    s_next.stopPtr = s_reg.wData[STOP_PTR_LSB +: PTR_W];
                end
                if (s_reg.wStrb[1]) begin
                    s_next.startPtr = s_reg.wData[START_PTR_LSB +: PTR_W];
                end
            end else if (addrOk(s_reg.wAddr)) begin
                tblWe = 1'b1;
                tblEvenSlot = evenSlotOf(idx);
            end
        end
        if (s_reg.bValid && s_axi_bready) begin
            s_next.bValid = 1'b0;
            s_next.awReady = 1'b1;
            s_next.wReady = 1'b1;
        end
        if (s_reg.arReady && s_axi_arvalid) begin
            idx = s_axi_araddr[IDX_MSB:IDX_LSB];
            es = evenSlotOf(idx);
            s_next.arReady = 1'b0;
            s_next.rValid = 1'b1;
            s_next.rResp = RESP_OKAY;
            s_next.rData = '0; // reserved bits read zero
            if (!addrOk(s_axi_araddr)) begin
                s_next.rResp = RESP_SLVERR;
            end else if (idx == BOUNDS_IDX) begin
                s_next.rData[START_PTR_LSB +: PTR_W] = s_reg.startPtr;
                s_next.rData[STOP_PTR_LSB +: PTR_W] = s_reg.stopPtr;
            end else begin
                s_next.rData[ODD_CODE_LSB +: CODE_W] = slotTable[es + 7'h01];
                s_next.rData[EVEN_CODE_LSB +: CODE_W] = slotTable[es];
            end
        end
        if (s_reg.rValid && s_axi_rready) begin
            s_next.rValid = 1'b0;
            s_next.arReady = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.awReady <= 1'b1;
            s_reg.wReady <= 1'b1;
            s_reg.arReady <= 1'b1;
            s_reg.startPtr <= START_PTR_RESET;
            s_reg.stopPtr <= STOP_PTR_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // table storage, byte lanes steer the two codes independently
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < SLOT_COUNT; i++) begin
                slotTable[i] <= SRC_GROUND;
            end
        end else if (tblWe) begin
            if (s_reg.wStrb[0]) begin
                slotTable[tblEvenSlot] <= s_reg.wData[EVEN_CODE_LSB +: CODE_W];
            end
            if (s_reg.wStrb[1]) begin
                slotTable[tblEvenSlot + 7'h01] <= s_reg.wData[ODD_CODE_LSB +: CODE_W];
            end
        end
    end

    // pointers 126 and 127 have no slot behind them; they read as ground
    assign codeAtPtr = (lookIdx < 7'(SLOT_COUNT)) ? slotTable[lookIdx] : SRC_GROUND;

    slot_sequencer u_seq (
        .ref_clk(ref_clk),
        .rst(rst),
        .seqStart(seqStart),
        .convAck(convAck),
        .startPtr(s_reg.startPtr),
        .stopPtr(s_reg.stopPtr), // stop below start ends after one slot
        .codeAtPtr(codeAtPtr),
        .lookIdx(lookIdx),
        .slot(slot),
        .seqBusy(seqBusy)
    );

    assign s_axi_awready = s_reg.awReady;
    assign s_axi_wready = s_reg.wReady;
    assign s_axi_bvalid = s_reg.bValid;
    assign s_axi_bresp = s_reg.bResp;
    assign s_axi_arready = s_reg.arReady;
    assign s_axi_rvalid = s_reg.rValid;
    assign s_axi_rresp = s_reg.rResp;
    assign s_axi_rdata = {16'h0000, s_reg.rData};

    // helper: a write with address bits 8..2 at 7Fh has completed since reset, aligned and mapped or not
    logic boundsWritten;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            boundsWritten <= 1'b0;
        end else if (s_reg.awHeld && s_reg.wHeld && s_reg.wAddr[IDX_MSB:IDX_LSB] == BOUNDS_IDX) begin
            boundsWritten <= 1'b1;
        end
    end

    // helper: an aligned bounds write commits this cycle
    logic boundsCommit;
    assign boundsCommit = s_reg.awHeld && s_reg.wHeld && s_reg.wAddr[1:0] == 2'h0
        && (s_reg.wAddr >> IDX_LSB) == AW'(BOUNDS_IDX);

    // helper: even slot behind the read address, worked out apart from evenSlotOf
    logic [PTR_W-1:0] rdEvenSlot;
    assign rdEvenSlot = PTR_W'((s_axi_araddr >> 1) - AW'({PAIR_FIRST_IDX, 1'b0}));

    // helper: the two table codes a pair read should return
    logic [CODE_W-1:0] rdEvenCode;
    logic [CODE_W-1:0] rdOddCode;
    assign rdEvenCode = (rdEvenSlot < PTR_W'(SLOT_COUNT)) ? slotTable[rdEvenSlot] : SRC_GROUND;
    assign rdOddCode = (rdEvenSlot < PTR_W'(SLOT_COUNT - 1)) ? slotTable[rdEvenSlot + 7'h01] : SRC_GROUND;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_bounds_reset_val: assert property (
        !boundsWritten |-> s_reg.startPtr == START_PTR_RESET && s_reg.stopPtr == STOP_PTR_RESET
    ) else $error("bounds register lost its reset value");
    a_pair_reserved_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[15] == 1'b0 && (s_axi_rdata[7] == 1'b0)
            && (s_axi_rdata[31:16] == 16'h0000)
    ) else $error("reserved read bits not zero");
    a_even_write_lands: assert property (
        tblWe && s_reg.wStrb[0] |=> slotTable[$past(tblEvenSlot)] == $past(s_reg.wData[EVEN_CODE_LSB +: CODE_W])
    ) else $error("even slot code not stored from bits 2..0");
    a_unmapped_errors: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr[IDX_MSB:IDX_LSB] < PAIR_FIRST_IDX
            |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR
    ) else $error("read below the table was not refused");
    a_write_answered: assert property (
        s_reg.awHeld && s_reg.wHeld |=> s_axi_bvalid ##0 !s_axi_awready [*1]
    ) else $error("write not answered one cycle after commit");

    // write side: answer codes and reopening of the channels
    a_pair_write_okay: assert property (
        s_reg.awHeld && s_reg.wHeld && s_reg.wAddr[1:0] == 2'h0
            && (s_reg.wAddr >> IDX_LSB) >= AW'(PAIR_FIRST_IDX) && (s_reg.wAddr >> IDX_LSB) <= AW'(PAIR_LAST_IDX)
            |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY
    ) else $error("write to a slot-pair register refused");
    a_low_write_errors: assert property (
        s_reg.awHeld && s_reg.wHeld && (s_reg.wAddr >> IDX_LSB) < AW'(PAIR_FIRST_IDX)
            |=> s_axi_bresp == RESP_SLVERR && $stable(s_reg.startPtr) && $stable(s_reg.stopPtr)
    ) else $error("write below the table was not refused");
    a_write_ready_back: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready
    ) else $error("write channels not reopened after the response");

    // read side: answer timing and field placement
    a_read_answer_next: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready
    ) else $error("read not answered the cycle after acceptance");
    a_ar_blocked: assert property (
        s_axi_rvalid |-> !s_axi_arready
    ) else $error("read address open while data pending");
    a_read_ready_back: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready
    ) else $error("read channel not reopened after the data");
    a_bounds_read_fields: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == AW'({BOUNDS_IDX, 2'h0})
            |=> s_axi_rdata == {16'h0000, 1'b0, $past(s_reg.startPtr), 1'b0, $past(s_reg.stopPtr)}
    ) else $error("bounds read fields misplaced");
    a_pair_read_fields: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] == 2'h0
            && (s_axi_araddr >> IDX_LSB) >= AW'(PAIR_FIRST_IDX) && (s_axi_araddr >> IDX_LSB) <= AW'(PAIR_LAST_IDX)
            |=> s_axi_rdata[EVEN_CODE_LSB +: CODE_W] == $past(rdEvenCode)
            && s_axi_rdata[ODD_CODE_LSB +: CODE_W] == $past(rdOddCode)
    ) else $error("pair read fields misplaced");

    // table lanes and bounds fields on commit
    a_odd_write_lands: assert property (
        tblWe && s_reg.wStrb[1]
            |=> slotTable[$past(tblEvenSlot) + 7'h01] == $past(s_reg.wData[ODD_CODE_LSB +: CODE_W])
    ) else $error("odd slot code not stored from bits 10..8");
    a_odd_lane_kept: assert property (
        tblWe && !s_reg.wStrb[1]
            |=> slotTable[$past(tblEvenSlot) + 7'h01] == $past(slotTable[tblEvenSlot + 7'h01])
    ) else $error("odd slot code changed without its strobe");
    a_stop_write: assert property (
        boundsCommit && s_reg.wStrb[0] |=> s_reg.stopPtr == $past(s_reg.wData[STOP_PTR_LSB +: PTR_W])
    ) else $error("stop pointer not taken from bits 6..0");
    a_start_write: assert property (
        boundsCommit && s_reg.wStrb[1] |=> s_reg.startPtr == $past(s_reg.wData[START_PTR_LSB +: PTR_W])
    ) else $error("start pointer not taken from bits 14..8");
    a_bounds_kept: assert property (
        !boundsCommit |=> $stable(s_reg.startPtr) && $stable(s_reg.stopPtr)
    ) else $error("bounds changed without a bounds write");

    c_pair_write: cover property (tblWe && s_reg.wStrb == 2'h3);
    c_bounds_read: cover property (s_axi_rvalid && s_axi_rresp == RESP_OKAY && boundsWritten);
    c_slverr_write: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    c_lane_write: cover property (tblWe && s_reg.wStrb == 2'h1);
endmodule : adc_custom_sequence_config

// ===== src/seq_cfg_pkg.sv
// Summary of operation
// - each slot holds a 3-bit source code: ground, two senses, two inputs, temperature
// - odd slot code in bits 10..8, even slot code in bits 2..0, rest reserved
// - sixty-three slot-pair registers sit at consecutive indexes 40h through 7Eh
// - bounds register at 7Fh resets to 0004h: start 14..8 zero, stop 6..0 four
package seq_cfg_pkg;
    localparam int PTR_W = 7;
    localparam int CODE_W = 3;
    localparam int REG_W = 16;
    localparam int SLOT_COUNT = 126;
    localparam int MIN_ADDR_W = 9;

    // register indexes; byte address is four times the index
    localparam logic [6:0] PAIR_FIRST_IDX = 7'h40;
    localparam logic [6:0] PAIR_LAST_IDX = 7'h7E;
    localparam logic [6:0] BOUNDS_IDX = 7'h7F;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 8;

    // field positions
    localparam int ODD_CODE_LSB = 8;
    localparam int EVEN_CODE_LSB = 0;
    localparam int START_PTR_LSB = 8;
    localparam int STOP_PTR_LSB = 0;

    // reset values
    localparam logic [PTR_W-1:0] START_PTR_RESET = 7'h00;
    localparam logic [PTR_W-1:0] STOP_PTR_RESET = 7'h04;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [CODE_W-1:0] {
        SRC_GROUND = 3'h0,
        SRC_FIRST_CURRENT_SENSE = 3'h1,
        SRC_SECOND_CURRENT_SENSE = 3'h2,
        SRC_FIRST_EXTERNAL_INPUT = 3'h3,
        SRC_SECOND_EXTERNAL_INPUT = 3'h4,
        SRC_TEMPERATURE_SENSOR = 3'h5
    } source_t;

    // one slot handed to the conversion engine
    typedef struct packed {
        logic valid;
        logic [PTR_W-1:0] index;
        logic [CODE_W-1:0] code;
    } slot_t;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_FETCH = 3'b010,
        SEQ_PRESENT = 3'b100
    } seq_state_t;
endpackage : seq_cfg_pkg

// ===== src/slot_sequencer.sv
`timescale 1ns/1ps
module slot_sequencer (
    input wire logic ref_clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic seqStart, // pulse: begin a pass
    input wire logic convAck, // engine took the presented slot
    input wire logic [seq_cfg_pkg::PTR_W-1:0] startPtr, // first slot
    input wire logic [seq_cfg_pkg::PTR_W-1:0] stopPtr, // last slot
    input wire logic [seq_cfg_pkg::CODE_W-1:0] codeAtPtr, // table code at lookIdx
    output logic [seq_cfg_pkg::PTR_W-1:0] lookIdx, // table lookup index
    output seq_cfg_pkg::slot_t slot, // presented slot
    output logic seqBusy // pass in progress
);
    import seq_cfg_pkg::*;

    typedef struct packed {
        seq_state_t state;
        logic [PTR_W-1:0] ptr;
        logic [PTR_W-1:0] stop;
        slot_t slot;
        logic busy;
    } seq_t;

    seq_t s_reg;
    seq_t s_next;

    // walk the table one slot per accepted conversion
    always_comb begin
        s_next = s_reg;
        case (s_reg.state)
            SEQ_IDLE: begin
                if (seqStart) begin
                    s_next.ptr = startPtr;
                    s_next.stop = stopPtr; // bounds frozen for the pass
                    s_next.state = SEQ_FETCH;
                end
            end
            SEQ_FETCH: begin
                s_next.slot.code = codeAtPtr;
                s_next.slot.index = s_reg.ptr;
                s_next.slot.valid = 1'b1;
                s_next.state = SEQ_PRESENT;
            end
            SEQ_PRESENT: begin
                if (convAck) begin
                    s_next.slot.valid = 1'b0;
                    // >= also ends a pass that software misprogrammed
                    if (s_reg.ptr >= s_reg.stop) begin
                        s_next.state = SEQ_IDLE;
                    end else begin
                        s_next.ptr = s_reg.ptr + 7'h01;
                        s_next.state = SEQ_FETCH;
                    end
                end
            end
            default: s_next.state = SEQ_IDLE;
        endcase
        // busy kept in a flop so the port needs no decode after the register
        s_next.busy = (s_next.state != SEQ_IDLE);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '{state: SEQ_IDLE, ptr: '0, stop: '0, slot: '0, busy: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign lookIdx = s_reg.ptr;
    assign slot = s_reg.slot;
    assign seqBusy = s_reg.busy;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_next_slot_up: assert property (
        slot.valid && convAck && (s_reg.ptr < s_reg.stop) |-> ##2 slot.valid && slot.index == $past(slot.index, 2) + 7'h01
    ) else $error("sequencer did not advance to the next slot");
    a_pass_ends_stop: assert property (
        slot.valid && convAck && (s_reg.ptr >= s_reg.stop) |=> !seqBusy
    ) else $error("sequencer ran past the stop pointer");
    a_code_from_table: assert property (
        s_reg.state == SEQ_FETCH |=> slot.code == $past(codeAtPtr) && slot.index == $past(lookIdx)
    ) else $error("presented code differs from table entry");
    c_full_pass: cover property (seqStart && !seqBusy ##[1:20] slot.valid && convAck && s_reg.ptr == s_reg.stop);
endmodule : slot_sequencer

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`define CHECK_EQ(what, expv, gotv) begin checks++; if ((gotv) !== (expv)) begin fails++; \
    $display("Error %s expected %h seen %h", what, expv, gotv); end end

module testbench;
    import seq_cfg_pkg::*;

    logic ref_clk;
    logic rst;
    logic [11:0] s_axi_awaddr;
    logic [11:0] s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata;
    logic [31:0] s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp;
    logic [1:0] s_axi_rresp;
    logic seqStart;
    logic convAck;
    logic seqBusy;
    slot_t slot;
    int fails;
    int checks;
    logic [1:0] resp;
    logic [31:0] data;

    adc_custom_sequence_config #(.AW(12)) dut_u (
        .ref_clk(ref_clk), .rst(rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .seqStart(seqStart), .convAck(convAck), .slot(slot), .seqBusy(seqBusy)
    );

    // free-running 200 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // byte address of a register index: one aligned word each
    function automatic logic [11:0] addr_of(input logic [6:0] idx);
        return {3'h0, idx, 2'h0};
    endfunction : addr_of

    // address and data offered together, each dropped when taken
    task automatic bus_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 1'b0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : bus_write

    // rready held from the start; data taken at the handshake edge
    task automatic bus_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 1'b0;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : bus_read

    // wait for a presented slot, check it, acknowledge with a one-cycle pulse
    task automatic take_slot(input logic [6:0] idx, input logic [2:0] code);
        do @(posedge ref_clk); while (slot.valid !== 1'b1);
        `CHECK_EQ("slot index", idx, slot.index)
        `CHECK_EQ("slot code", code, slot.code)
        `CHECK_EQ("busy in pass", 1'b1, seqBusy)
        convAck <= 1'b1;
        @(posedge ref_clk);
        convAck <= 1'b0;
    endtask : take_slot

    task automatic tally_and_finish;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish

    // main sequence
    initial begin
        rst = 1'b1;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        seqStart = 1'b0;
        convAck = 1'b0;
        fails = 0;
        checks = 0;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        bus_read(addr_of(BOUNDS_IDX), data, resp);
        `CHECK_EQ("bounds reset", 32'h0000_0004, data)
        bus_read(addr_of(7'h60), data, resp);
        `CHECK_EQ("pair reset", 32'h0000_0000, data)
        // every source code once in each lane, both table ends, reserved bits set high
        for (int c = 0; c < 6; c++) begin
            bus_write(addr_of(c == 5 ? PAIR_LAST_IDX : PAIR_FIRST_IDX + 7'(c)),
                32'hFFFF_F8F8 | 32'((c << 8) | (5 - c)), resp);
            `CHECK_EQ("pair write resp", RESP_OKAY, resp)
        end
        // an unmapped write must not land in the first pair register
        bus_write(addr_of(7'h3F), 32'h0000_0101, resp);
        `CHECK_EQ("unmapped write resp", RESP_SLVERR, resp)
        for (int c = 0; c < 6; c++) begin
            bus_read(addr_of(c == 5 ? PAIR_LAST_IDX : PAIR_FIRST_IDX + 7'(c)), data, resp);
            `CHECK_EQ("pair readback", 32'((c << 8) | (5 - c)), data)
            `CHECK_EQ("pair read resp", RESP_OKAY, resp)
        end
        // byte lane 0 only: the odd code in lane 1 must stay as it was
        s_axi_wstrb <= 4'h1;
        bus_write(addr_of(PAIR_FIRST_IDX), 32'h0000_0303, resp);
        s_axi_wstrb <= 4'hF;
        bus_read(addr_of(PAIR_FIRST_IDX), data, resp);
        `CHECK_EQ("lane 0 write", 32'h0000_0003, data)
        bus_read(12'h200, data, resp);
        `CHECK_EQ("unmapped read resp", RESP_SLVERR, resp)
        `CHECK_EQ("unmapped read data", 32'h0000_0000, data)
        bus_read(12'h101, data, resp);
        `CHECK_EQ("unaligned read resp", RESP_SLVERR, resp)
        bus_write(addr_of(BOUNDS_IDX), 32'hFFFF_FFFF, resp);
        bus_read(addr_of(BOUNDS_IDX), data, resp);
        `CHECK_EQ("bounds reserved", 32'h0000_7F7F, data)
        // pass over slots 2..4; stop kept at or above start
        bus_write(addr_of(BOUNDS_IDX), 32'h0000_0204, resp);
        bus_write(addr_of(7'h41), 32'h0000_0503, resp);
        bus_write(addr_of(7'h42), 32'h0000_0402, resp);
        @(posedge ref_clk);
        seqStart <= 1'b1;
        @(posedge ref_clk);
        seqStart <= 1'b0;
        take_slot(7'h02, SRC_FIRST_EXTERNAL_INPUT);
        take_slot(7'h03, SRC_TEMPERATURE_SENSOR);
        take_slot(7'h04, SRC_SECOND_CURRENT_SENSE);
        repeat (2) @(posedge ref_clk);
        `CHECK_EQ("busy after stop", 1'b0, seqBusy)
        `CHECK_EQ("no slot after stop", 1'b0, slot.valid)
        tally_and_finish();
    end

    // hang guard: the whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        tally_and_finish();
    end
endmodule : testbench
